// file: common/ipd_pkg.sv
// Purpose: Shared constants and carrier types for the doorbell block.
// Assumes: 32-bit AXI4-Lite register bus, one word per register.
// Notes: Offsets are byte addresses.
package ipd_pkg;

  localparam int unsigned IPD_NUM_SOURCES = 32;
  localparam int unsigned IPD_ADDR_W = 5;

  localparam logic [4:0] IPD_OFF_PENDING_SET = 5'h00;
  localparam logic [4:0] IPD_OFF_PENDING_CLEAR = 5'h04;
  localparam logic [4:0] IPD_OFF_PENDING_STATE = 5'h08;
  localparam logic [4:0] IPD_OFF_MASK_ENABLE = 5'h0c;
  localparam logic [4:0] IPD_OFF_MASK_DISABLE = 5'h10;
  localparam logic [4:0] IPD_OFF_MASK_STATE = 5'h14;
  localparam logic [4:0] IPD_OFF_ACTIVE_STATUS = 5'h18;

  localparam logic [31:0] IPD_RST_PENDING = 32'h0000_0000;
  localparam logic [31:0] IPD_RST_MASK = 32'h0000_0000;

  localparam logic [1:0] IPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPD_RESP_SLVERR = 2'h2;

  // One decoded register write, presented to the source bank.
  typedef struct packed {
    logic set_pend;
    logic clr_pend;
    logic en_mask;
    logic dis_mask;
    logic [31:0] data;
    logic [3:0] strb;
  } ipd_wcmd_t;

  // State of the source bank.
  typedef struct packed {
    logic [31:0] pending;
    logic [31:0] mask;
    logic irq;
  } ipd_bank_t;

  typedef enum logic [1:0] {
    IPD_W_IDLE = 2'b00,
    IPD_W_RESP = 2'b01
  } ipd_wstate_t;

  typedef enum logic [1:0] {
    IPD_R_IDLE = 2'b00,
    IPD_R_DATA = 2'b01
  } ipd_rstate_t;

endpackage : ipd_pkg

// file: src/ipd_doorbell.sv
// Purpose: Inter-processor doorbell with 32 sources behind AXI4-Lite.
// Assumes: One clock, synchronous active-low reset.
// Notes: Single outstanding write and read; answers take one cycle.
//
// Operation
// - Thirty-two sources, source n at bit n of every register.
// - Interrupt output is the OR of all pending and enabled sources.
// - Writing one to set command bit n makes source n pending.
// - Writing one to clear command bit n removes pending of source n.
// - Pending register reads pending bits and resets to zero.
// - Writing one to enable command bit n sets mask bit n.
// - Writing one to disable command bit n clears mask bit n.
// - Mask register reads mask bits and resets to zero.
// - Status register reads pending AND mask and resets to zero.
// - One enable or disable write changes any subset of mask bits.
// - Masked sources never affect the output but stay pending.
`timescale 1ns/1ps
`default_nettype none
module ipd_doorbell (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import ipd_pkg::*;

  typedef struct packed {
    ipd_wstate_t wst;
    logic aw_held;
    logic [4:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    ipd_rstate_t rst;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipd_bus_t;

  ipd_bus_t st;
  ipd_bus_t next_st;
  ipd_wcmd_t cmd;
  ipd_bank_t bank;
  logic aw_take;
  logic w_take;
  logic [4:0] waddr_eff;
  logic [31:0] wdata_eff;
  logic [3:0] wstrb_eff;
  logic wfire;

  // Only aligned words in the mapped range answer OKAY.
  function automatic logic addr_ok(input logic [4:0] a, input logic wr);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0) begin
      case (a)
        IPD_OFF_PENDING_SET, IPD_OFF_PENDING_CLEAR,
        IPD_OFF_MASK_ENABLE, IPD_OFF_MASK_DISABLE: ok = 1'b1;
        IPD_OFF_PENDING_STATE, IPD_OFF_MASK_STATE,
        IPD_OFF_ACTIVE_STATUS: ok = !wr;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : addr_ok

  ipd_source_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd(cmd),
    .bank(bank)
  );

  always_comb begin
    next_st = st;
    aw_take = s_axi_awvalid && st.awready;
    w_take = s_axi_wvalid && st.wready;
    waddr_eff = st.aw_held ? st.awaddr : s_axi_awaddr;
    wdata_eff = st.w_held ? st.wdata : s_axi_wdata;
    wstrb_eff = st.w_held ? st.wstrb : s_axi_wstrb;
    wfire = 1'b0;
    cmd = '0;

    case (st.wst)
      IPD_W_IDLE: begin
        if (aw_take) begin
          next_st.aw_held = 1'b1;
          next_st.awaddr = s_axi_awaddr;
          next_st.awready = 1'b0;
        end
        if (w_take) begin
          next_st.w_held = 1'b1;
          next_st.wdata = s_axi_wdata;
          next_st.wstrb = s_axi_wstrb;
          next_st.wready = 1'b0;
        end
        // Address and data may arrive in either order.
        if ((st.aw_held || aw_take) && (st.w_held || w_take)) begin
          wfire = 1'b1;
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
          next_st.awready = 1'b0;
          next_st.wready = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.bresp = addr_ok(waddr_eff, 1'b1) ? IPD_RESP_OKAY
                                                   : IPD_RESP_SLVERR;
          next_st.wst = IPD_W_RESP;
        end
      end
      IPD_W_RESP: begin
        if (s_axi_bready) begin
          next_st.bvalid = 1'b0;
          next_st.awready = 1'b1;
          next_st.wready = 1'b1;
          next_st.wst = IPD_W_IDLE;
        end
      end
      default: begin
        next_st.wst = IPD_W_IDLE;
      end
    endcase

    if (wfire) begin
      cmd.data = wdata_eff;
      cmd.strb = wstrb_eff;
      cmd.set_pend = (waddr_eff == IPD_OFF_PENDING_SET);
      cmd.clr_pend = (waddr_eff == IPD_OFF_PENDING_CLEAR);
      cmd.en_mask = (waddr_eff == IPD_OFF_MASK_ENABLE);
      cmd.dis_mask = (waddr_eff == IPD_OFF_MASK_DISABLE);
    end

    case (st.rst)
      IPD_R_IDLE: begin
        if (s_axi_arvalid && st.arready) begin
          next_st.arready = 1'b0;
          next_st.rvalid = 1'b1;
          next_st.rresp = addr_ok(s_axi_araddr, 1'b0) ? IPD_RESP_OKAY
                                                      : IPD_RESP_SLVERR;
          // Reads never touch the bank, so command offsets are harmless.
          case (s_axi_araddr)
            IPD_OFF_PENDING_STATE: next_st.rdata = bank.pending;
            IPD_OFF_MASK_STATE: next_st.rdata = bank.mask;
            IPD_OFF_ACTIVE_STATUS: begin
              next_st.rdata = bank.pending & bank.mask;
            end
            default: next_st.rdata = 32'h0000_0000;
          endcase
          next_st.rst = IPD_R_DATA;
        end
      end
      IPD_R_DATA: begin
        if (s_axi_rready) begin
          next_st.rvalid = 1'b0;
          next_st.arready = 1'b1;
          next_st.rst = IPD_R_IDLE;
        end
      end
      default: begin
        next_st.rst = IPD_R_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.wst <= IPD_W_IDLE;
      st.rst <= IPD_R_IDLE;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign irq = bank.irq;
endmodule : ipd_doorbell
`default_nettype wire

// file: src/ipd_source_bank.sv
// Purpose: Pending and mask bits for the doorbell sources, with output.
// Assumes: Write commands arrive as one-cycle strobes on the same clock.
// Notes: Byte strobes gate which command bits take effect.
`timescale 1ns/1ps
`default_nettype none
module ipd_source_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ipd_pkg::ipd_wcmd_t cmd,
  output ipd_pkg::ipd_bank_t bank
);
  import ipd_pkg::*;

  ipd_bank_t state;
  ipd_bank_t next_state;
  logic [31:0] bits;

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  always_comb begin
    next_state = state;
    bits = cmd.data & strb_mask(cmd.strb);
    // Only ones act; zeros leave each source alone.
    if (cmd.set_pend) begin
      next_state.pending = state.pending | bits;
    end
    if (cmd.clr_pend) begin
      next_state.pending = state.pending & ~bits;
    end
    // Whole subsets change in one write, no read-modify-write.
    if (cmd.en_mask) begin
      next_state.mask = state.mask | bits;
    end
    if (cmd.dis_mask) begin
      next_state.mask = state.mask & ~bits;
    end
    // Masked sources keep their pending bit but never reach the output.
    next_state.irq = |(next_state.pending & next_state.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state.pending <= IPD_RST_PENDING;
      state.mask <= IPD_RST_MASK;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign bank = state;
endmodule : ipd_source_bank
`default_nettype wire

// file: test/interprocessor_doorbell_irq_bench.sv
// Purpose: Self-checking bench for the doorbell block.
// Assumes: AXI4-Lite master tasks, one word per access.
// Notes: Random data, and in the middle pass random strobes, from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module interprocessor_doorbell_irq_bench;
  import ipd_pkg::*;
  logic aclk = 0, aresetn = 0, irq;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, pend, mask, m;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, er;
  logic [15:0] rises;
  logic [4:0] offs[9] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14,
    5'h18, 5'h1c, 5'h02};
  int miscompares = 0, cmp_count = 0, cyc = 0, exp_rises = 0;
  int seed = 32'hae9b7cb0;
  // The clock runs from time zero, so it is live before any access.
  always #10 aclk = ~aclk;
  ipd_doorbell dut (.*);
  ipd_irq_ctrl u_ctrl (.aclk(aclk), .irq(irq), .rises(rises));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] s);
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & d;
    er = 2'h0;
    if (!(|(pend & mask)) && a == 5'h00 && |(m & mask & ~pend)) exp_rises++;
    if (!(|(pend & mask)) && a == 5'h0c && |(m & pend & ~mask)) exp_rises++;
    case (a)
      5'h00: pend = pend | m;
      5'h04: pend = pend & ~m;
      5'h0c: mask = mask | m;
      5'h10: mask = mask & ~m;
      default: er = 2'h2;
    endcase
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    chk("irq", {31'h0, irq}, {31'h0, |(pend & mask)});
  endtask : wr
  task automatic rd(input logic [4:0] a);
    er = (a > 5'h18 || a[1:0] != 2'h0) ? 2'h2 : 2'h0;
    m = 32'h0;
    if (a == 5'h08 || a == 5'h18) m = pend;
    if (a == 5'h14 || a == 5'h18) m = (a == 5'h18) ? m & mask : mask;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, m);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic rst();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    pend = 32'h0;
    mask = 32'h0;
  endtask : rst
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Random strobes in the middle pass exercise the byte-lane gating.
  initial begin
    rst();
    for (int t = 0; t < 3; t++) begin
      foreach (offs[i]) rd(offs[i]);
      repeat (60) begin
        wr(offs[{$random(seed)} % 9], $random(seed),
          (t == 1) ? 4'($random(seed)) : 4'hf);
        rd(offs[{$random(seed)} % 9]);
      end
      $display("test %0d done", t);
      rst();
    end
    chk("irq rises", {16'h0, rises}, 32'(exp_rises));
    final_report();
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
endmodule : interprocessor_doorbell_irq_bench
`default_nettype wire

// file: test/ipd_doorbell_chk.sv
// Purpose: Bus and interrupt timing checks at the doorbell ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module ipd_doorbell_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr |=> s_axi_bvalid)
    else $error("write answer late");
  a_aw_drop: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("awready stayed high");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready
    |=> s_axi_awready && s_axi_wready) else $error("readies not back");
  a_read_answer: assert property (s_rd |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp[1]
    |-> s_axi_rdata == 32'h0) else $error("error read not zero");
  a_irq_cause: assert property ($changed(irq)
    |-> $rose(s_axi_bvalid)) else $error("irq moved without write");
endmodule : ipd_doorbell_chk
bind ipd_doorbell ipd_doorbell_chk u_chk (.*);
`default_nettype wire

// file: test/ipd_irq_ctrl.sv
// Purpose: Stand-in interrupt controller that counts doorbell raises.
// Assumes: Same clock as the block; level input.
// Notes: Counts only rising edges, as an edge-sensitive core would.
`timescale 1ns/1ps
`default_nettype none
module ipd_irq_ctrl (
  input wire logic aclk,
  input wire logic irq,
  output logic [15:0] rises
);
  logic irq_q = 1'b0;
  logic [15:0] cnt = 16'h0;
  assign rises = cnt;
  // Listening from time zero, before any source is enabled.
  always @(posedge aclk) begin
    irq_q <= irq;
    if (irq && !irq_q) cnt <= cnt + 16'h1;
  end
endmodule : ipd_irq_ctrl
`default_nettype wire
